// >>> hdl/qdsp_command_port.sv
// Serial command front end of a quad 12-bit DAC
`timescale 1ns/1ps
module qdsp_command_port (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     sys_rst,
   // Serial link pins
   input  wire qdsp_pkg::qdsp_link_t     linkIn,
   output logic                          echoOut,
   // Control pins
   input  wire logic                     clearAllN,
   input  wire logic                     shutdownLockoutN,
   output logic                          userLogicOutput,
   output logic                          echoOnRise,
   // Converter side
   output qdsp_pkg::qdsp_dac_state_t     dacState
);

   typedef struct packed {
      qdsp_pkg::qdsp_link_t   linkMeta;
      qdsp_pkg::qdsp_link_t   linkSync;
      logic [1:0]             lineMeta;
      logic [1:0]             lineSync;
      logic                   sclkPrev;
      logic                   pdlPrev;
      qdsp_pkg::qdsp_phase_t  phase;
      logic [15:0]            shiftReg;
      logic [4:0]             bitCount;
      logic                   spill;
      logic [3:0][11:0]       inputReg;
      logic [3:0][11:0]       dacReg;
      logic                   userOut;
      logic                   echoMode;
      logic                   powerDown;
      logic                   echoOut;
   } qdsp_state_t;

   // Reset value: synchronisers hold idle pin levels so no false frame follows reset
   localparam qdsp_state_t RESET_ST = '{
      linkMeta: '{sclk: 1'h0, csN: 1'h1, din: 1'h0},
      linkSync: '{sclk: 1'h0, csN: 1'h1, din: 1'h0},
      lineMeta: 2'h3,
      lineSync: 2'h3,
      pdlPrev:  1'h1,
      phase:    qdsp_pkg::PH_IDLE,
      userOut:  qdsp_pkg::USER_RESET,
      echoMode: qdsp_pkg::ECHO_FALL,
      default:  '0
   };

   qdsp_state_t          st;
   qdsp_state_t          next_st;
   logic                 sclkRise;
   logic                 sclkFall;
   logic                 csLow;
   logic                 clearing;
   logic                 shutdown_lockout_n;
   logic                 pdlFall;
   logic                 frameEnd;
   logic                 applyNow;
   logic [1:0]           addr;
   logic [11:0]          data;
   qdsp_pkg::qdsp_action_t act;

   // Map the four address and control bits to an action
   function automatic qdsp_pkg::qdsp_action_t cmdAction(input logic [3:0] code);
      qdsp_pkg::qdsp_action_t a;
      a = qdsp_pkg::ACT_NONE;
      if (code[1:0] == qdsp_pkg::CTRL_LOAD) begin
         a = qdsp_pkg::ACT_LOAD;
      end else if (code[1:0] == qdsp_pkg::CTRL_LOADUPD) begin
         a = qdsp_pkg::ACT_LOAD_UPD;
      end else begin
         case (code)
            qdsp_pkg::CMD_UPDATE:   a = qdsp_pkg::ACT_UPDATE;
            qdsp_pkg::CMD_LOAD_ALL: a = qdsp_pkg::ACT_LOAD_ALL;
            qdsp_pkg::CMD_SHUTDOWN: a = qdsp_pkg::ACT_SHUTDOWN;
            qdsp_pkg::CMD_USER_LO:  a = qdsp_pkg::ACT_USER_LO;
            qdsp_pkg::CMD_USER_HI:  a = qdsp_pkg::ACT_USER_HI;
            qdsp_pkg::CMD_ECHO1:    a = qdsp_pkg::ACT_ECHO1;
            qdsp_pkg::CMD_ECHO0:    a = qdsp_pkg::ACT_ECHO0;
            default:                a = qdsp_pkg::ACT_NONE;
         endcase
      end
      return a;
   endfunction : cmdAction

   // Actions that copy input registers to DAC registers
   function automatic logic copiesAll(input qdsp_pkg::qdsp_action_t a);
      return (a == qdsp_pkg::ACT_LOAD_UPD) || (a == qdsp_pkg::ACT_UPDATE) ||
             (a == qdsp_pkg::ACT_ECHO1) || (a == qdsp_pkg::ACT_ECHO0);
   endfunction : copiesAll

   // Edges and levels from the synchronised pins
   assign sclkRise = st.linkSync.sclk & ~st.sclkPrev;
   assign sclkFall = ~st.linkSync.sclk & st.sclkPrev;
   assign csLow    = ~st.linkSync.csN;
   assign clearing = ~st.lineSync[1];
   assign shutdown_lockout_n      = st.lineSync[0];
   assign pdlFall  = st.pdlPrev & ~shutdown_lockout_n;
   assign frameEnd = (st.phase == qdsp_pkg::PH_SHIFT) && !csLow;
   assign applyNow = frameEnd && (st.bitCount == qdsp_pkg::FRAME_LEN);
   assign addr     = st.shiftReg[qdsp_pkg::FRAME_MSB:qdsp_pkg::ADDR_LSB];
   assign data     = st.shiftReg[qdsp_pkg::DATA_MSB:0];
   assign act      = cmdAction(st.shiftReg[qdsp_pkg::FRAME_MSB:qdsp_pkg::CTRL_LSB]);

   // Next-state logic for the whole block
   always_comb begin
      next_st          = st;
      next_st.linkMeta = linkIn;
      next_st.linkSync = st.linkMeta;
      next_st.lineMeta = {clearAllN, shutdownLockoutN};
      next_st.lineSync = st.lineMeta;
      next_st.sclkPrev = st.linkSync.sclk;
      next_st.pdlPrev  = shutdown_lockout_n;

      case (st.phase)
         qdsp_pkg::PH_IDLE: begin
            // Clock and data ignored until chip select falls
            if (csLow) begin
               next_st.phase    = qdsp_pkg::PH_SHIFT;
               next_st.bitCount = sclkRise ? qdsp_pkg::COUNT_ONE : qdsp_pkg::COUNT_ZERO;
            end
         end
         qdsp_pkg::PH_SHIFT: begin
            if (!csLow) begin
               next_st.phase = qdsp_pkg::PH_IDLE;
            end else if (sclkRise && st.bitCount != qdsp_pkg::COUNT_OVER) begin
               next_st.bitCount = st.bitCount + qdsp_pkg::COUNT_ONE;
            end
         end
         default: next_st.phase = qdsp_pkg::PH_IDLE;
      endcase

      // Shift on rising edges, echo per selected mode
      if (csLow && sclkRise) begin
         next_st.shiftReg = {st.shiftReg[14:0], st.linkSync.din};
         next_st.spill    = st.shiftReg[qdsp_pkg::FRAME_MSB];
         if (st.echoMode == qdsp_pkg::ECHO_RISE) begin
            next_st.echoOut = st.shiftReg[qdsp_pkg::FRAME_MSB];
         end
      end
      if (csLow && sclkFall && st.echoMode == qdsp_pkg::ECHO_FALL) begin
         next_st.echoOut = st.spill;
      end

      // Frame effects at the chip select rise
      if (applyNow) begin
         case (act)
            qdsp_pkg::ACT_LOAD: begin
               next_st.inputReg[addr] = data;
            end
            qdsp_pkg::ACT_LOAD_UPD: begin
               next_st.inputReg[addr] = data;
            end
            qdsp_pkg::ACT_UPDATE: begin
               next_st.powerDown = 1'h0;
            end
            qdsp_pkg::ACT_LOAD_ALL: begin
               for (int i = 0; i < qdsp_pkg::CHANNELS; i++) begin
                  next_st.inputReg[i] = data;
                  next_st.dacReg[i]   = data;
               end
               next_st.powerDown = 1'h0;
            end
            qdsp_pkg::ACT_SHUTDOWN: begin
               if (shutdown_lockout_n) begin
                  next_st.powerDown = 1'h1;
               end
            end
            qdsp_pkg::ACT_USER_LO: next_st.userOut  = 1'h0;
            qdsp_pkg::ACT_USER_HI: next_st.userOut  = 1'h1;
            qdsp_pkg::ACT_ECHO1:   next_st.echoMode = qdsp_pkg::ECHO_RISE;
            qdsp_pkg::ACT_ECHO0:   next_st.echoMode = qdsp_pkg::ECHO_FALL;
            default: ;
         endcase
         if (copiesAll(act)) begin
            next_st.dacReg = next_st.inputReg;
         end
      end

      // Lockout falling edge wakes with retained values
      if (st.powerDown && pdlFall) begin
         next_st.powerDown = 1'h0;
      end

      // Clear pin overrides everything else
      if (clearing) begin
         next_st.inputReg  = '0;
         next_st.dacReg    = '0;
         next_st.userOut   = qdsp_pkg::USER_RESET;
         next_st.echoOut   = 1'h0;
         next_st.spill     = 1'h0;
         next_st.echoMode  = qdsp_pkg::ECHO_FALL;
         next_st.powerDown = 1'h0;
      end
   end

   // State register, loaded with RESET_ST on reset
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st <= RESET_ST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state
   assign echoOut            = st.echoOut;
   assign userLogicOutput    = st.userOut;
   assign echoOnRise         = st.echoMode;
   assign dacState.powerDown = st.powerDown;
   assign dacState.dacValue  = st.dacReg;

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   // Serial state frozen while deselected
   idle_freeze_a: assert property (
      !csLow |=> $stable(st.shiftReg))
      else $error("shift register moved while deselected");

   // One bit enters per rising edge
   shift_in_a: assert property (
      csLow && sclkRise |=> st.shiftReg[0] == $past(st.linkSync.din)
         && st.shiftReg[15:1] == $past(st.shiftReg[14:0]))
      else $error("shift register did not take input bit");

   // DAC registers move only after a frame or clear
   dac_cause_a: assert property (
      !$stable(st.dacReg) |-> $past(applyNow) || $past(clearing))
      else $error("DAC registers changed without cause");

   // Short or long frames do nothing
   bad_frame_a: assert property (
      frameEnd && st.bitCount != qdsp_pkg::FRAME_LEN && !clearing
         |=> $stable(st.inputReg) && $stable(st.dacReg) && $stable(st.userOut))
      else $error("malformed frame had an effect");

   // Input load leaves DAC registers alone
   load_input_a: assert property (
      applyNow && act == qdsp_pkg::ACT_LOAD && !clearing
         |=> $stable(st.dacReg) && st.inputReg[$past(addr)] == $past(data))
      else $error("input load wrong");

   // Load and update copies all channels
   load_update_a: assert property (
      applyNow && act == qdsp_pkg::ACT_LOAD_UPD && !clearing
         |=> st.dacReg == st.inputReg && st.dacReg[$past(addr)] == $past(data))
      else $error("load and update wrong");

   // Shutdown refused while locked out
   lockout_a: assert property (
      applyNow && act == qdsp_pkg::ACT_SHUTDOWN && !shutdown_lockout_n && !st.powerDown
         |=> !st.powerDown)
      else $error("shutdown taken while locked out");

   // Lockout fall wakes the device
   pdl_wake_a: assert property (
      st.powerDown && pdlFall |=> !st.powerDown)
      else $error("lockout edge did not wake");

   // Clear zeroes outputs and registers
   clear_zero_a: assert property (
      clearing |=> st.dacReg == '0 && st.inputReg == '0 && !userLogicOutput && !echoOut)
      else $error("clear did not zero state");

   // Update command copies every input register
   update_all_a: assert property (
      applyNow && act == qdsp_pkg::ACT_UPDATE && !clearing
         |=> st.dacReg == $past(st.inputReg))
      else $error("update all did not copy input registers");

   // Load all puts one value everywhere
   load_all_a: assert property (
      applyNow && act == qdsp_pkg::ACT_LOAD_ALL && !clearing
         |=> st.inputReg == {4{$past(data)}} && st.dacReg == {4{$past(data)}})
      else $error("load all wrong");

   // Update and load all leave power-down
   wake_cmd_a: assert property (
      applyNow && (act == qdsp_pkg::ACT_UPDATE || act == qdsp_pkg::ACT_LOAD_ALL)
         |=> !st.powerDown)
      else $error("startup command did not wake");

   // Shutdown taken while the lockout allows it
   shutdown_take_a: assert property (
      applyNow && act == qdsp_pkg::ACT_SHUTDOWN && shutdown_lockout_n && !clearing
         |=> st.powerDown)
      else $error("shutdown not taken");

   // Power-down keeps the input registers
   power_keep_a: assert property (
      st.powerDown && !applyNow && !clearing
         |=> $stable(st.inputReg))
      else $error("input registers lost in power-down");

   // User output follows its two commands
   user_out_a: assert property (
      applyNow && !clearing && (act == qdsp_pkg::ACT_USER_HI || act == qdsp_pkg::ACT_USER_LO)
         |=> userLogicOutput == ($past(act) == qdsp_pkg::ACT_USER_HI))
      else $error("user output wrong");

   // No-operation frame changes nothing
   nop_hold_a: assert property (
      applyNow && act == qdsp_pkg::ACT_NONE && !clearing
         |=> $stable(st.inputReg) && $stable(st.dacReg) && $stable(st.userOut))
      else $error("no-operation frame had an effect");

   // Echo mode commands set the edge and update all
   echo_mode_a: assert property (
      applyNow && !clearing && (act == qdsp_pkg::ACT_ECHO1 || act == qdsp_pkg::ACT_ECHO0)
         |=> echoOnRise == ($past(act) == qdsp_pkg::ACT_ECHO1) && st.dacReg == st.inputReg)
      else $error("echo mode command wrong");

   // Mode 1 echo takes the bit leaving the top
   echo_rise_a: assert property (
      csLow && sclkRise && st.echoMode == qdsp_pkg::ECHO_RISE && !clearing
         |=> echoOut == $past(st.shiftReg[qdsp_pkg::FRAME_MSB]))
      else $error("rising edge echo wrong");

   // Mode 0 echo shows the bit held since the last rise
   echo_fall_a: assert property (
      csLow && sclkFall && st.echoMode == qdsp_pkg::ECHO_FALL && !clearing
         |=> echoOut == $past(st.spill))
      else $error("falling edge echo wrong");

   // Echo stands still while deselected
   echo_idle_a: assert property (
      !csLow && !clearing
         |=> $stable(echoOut))
      else $error("echo moved while deselected");

   // Bit counter steps once per rising edge
   count_step_a: assert property (
      csLow && sclkRise && st.phase == qdsp_pkg::PH_SHIFT && st.bitCount != qdsp_pkg::COUNT_OVER
         |=> st.bitCount == $past(st.bitCount) + 5'h01)
      else $error("bit counter did not step");

   // Input registers move only at a frame end or clear
   input_cause_a: assert property (
      !$stable(st.inputReg)
         |-> $past(applyNow) || $past(clearing))
      else $error("input registers changed without cause");

   // Reset leaves zero code, low user output and echo mode 0
   reset_state_a: assert property (@(posedge clock) disable iff (1'b0)
      sys_rst
         |=> st.inputReg == '0 && st.dacReg == '0 && !userLogicOutput && !echoOnRise)
      else $error("reset state wrong");

   // Main scenarios reached
   cover property (applyNow && act == qdsp_pkg::ACT_LOAD_UPD);
   cover property (applyNow && act == qdsp_pkg::ACT_SHUTDOWN && shutdown_lockout_n);
   cover property (st.powerDown ##1 !st.powerDown);
   cover property (applyNow && act == qdsp_pkg::ACT_ECHO1);
   cover property (applyNow && act == qdsp_pkg::ACT_LOAD_ALL);

endmodule : qdsp_command_port

// >>> include/qdsp_pkg.sv
// Constants and types for the quad DAC serial command port
// How it works
// - A frame is 16 bits, MSB first: address, control code, 12 data bits.
// - Chip select high: serial logic idle, clock and data ignored.
// - Chip select low: each rising serial clock shifts one data bit in.
// - Frame is decoded and applied only when chip select rises.
// - Code x01: load addressed input register, DAC registers unchanged.
// - Code x11: load addressed input register, then update all DAC registers.
// - Code 0100: copy all input registers to DAC registers, data ignored.
// - Code 1000: one value into all input and DAC registers.
// - Code 1100: power down, only while the lockout input is high.
// - Power-down keeps serial interface running and input registers intact.
// - Update-all or load-all commands leave power-down.
// - Code 0010 drives user output low (default), 0110 drives it high.
// - Code 0000 changes nothing, for daisy chains.
// - Code 1110: echo on rising edges, and update all DAC registers.
// - Code 1010: echo on falling edges (default), and update all DAC registers.
// - Shift register contents leave serially on the echo output.
// - Echo lags input by 16.5 clocks in mode 0, 16 in mode 1.
// - Power-up clears input and DAC registers and selects echo mode 0.
// - Clear input low zeroes registers, user output and echo output.
// - Lockout falling edge in power-down wakes the device, outputs restored.
package qdsp_pkg;
   localparam int         DATA_W     = 12;
   localparam int         CHANNELS   = 4;
   localparam int         FRAME_MSB  = 15;
   localparam int         ADDR_LSB   = 14;
   localparam int         CTRL_LSB   = 12;
   localparam int         DATA_MSB   = 11;
   localparam logic [4:0] FRAME_LEN  = 5'h10;
   localparam logic [4:0] COUNT_OVER = 5'h11;
   localparam logic [4:0] COUNT_ZERO = 5'h00;
   localparam logic [4:0] COUNT_ONE  = 5'h01;
   localparam logic       ECHO_FALL  = 1'h0;
   localparam logic       ECHO_RISE  = 1'h1;
   localparam logic       USER_RESET = 1'h0;

   // Address and control codes, address bits first
   localparam logic [3:0] CMD_NOP      = 4'h0;
   localparam logic [3:0] CMD_USER_LO  = 4'h2;
   localparam logic [3:0] CMD_UPDATE   = 4'h4;
   localparam logic [3:0] CMD_USER_HI  = 4'h6;
   localparam logic [3:0] CMD_LOAD_ALL = 4'h8;
   localparam logic [3:0] CMD_ECHO0    = 4'hA;
   localparam logic [3:0] CMD_SHUTDOWN = 4'hC;
   localparam logic [3:0] CMD_ECHO1    = 4'hE;
   localparam logic [1:0] CTRL_LOAD    = 2'h1;
   localparam logic [1:0] CTRL_LOADUPD = 2'h3;

   typedef enum logic [3:0] {
      ACT_NONE, ACT_LOAD, ACT_LOAD_UPD, ACT_UPDATE, ACT_LOAD_ALL,
      ACT_SHUTDOWN, ACT_USER_LO, ACT_USER_HI, ACT_ECHO1, ACT_ECHO0
   } qdsp_action_t;

   typedef enum logic {PH_IDLE, PH_SHIFT} qdsp_phase_t;

   // Serial link pins as seen by the device
   typedef struct packed {
      logic sclk;
      logic csN;
      logic din;
   } qdsp_link_t;

   // Converter-facing state
   typedef struct packed {
      logic                             powerDown;
      logic [CHANNELS-1:0][DATA_W-1:0] dacValue;
   } qdsp_dac_state_t;
endpackage : qdsp_pkg

// >>> tb/qdsp_command_port_bench.sv
// Self-checking bench for the quad DAC serial command port
`timescale 1ns/1ps
module qdsp_command_port_bench;
   typedef struct packed {
      qdsp_pkg::qdsp_dac_state_t dac;
      logic                      user;
      logic                      rise;
   } qdsp_note_t;
   logic                      clock;
   logic                      sys_rst   = 1'b1;
   logic                      clearAllN = 1'b1;
   logic                      lockN     = 1'b1;
   logic                      echoOut;
   logic                      userOut;
   logic                      echoOnRise;
   qdsp_pkg::qdsp_link_t      linkIn;
   qdsp_pkg::qdsp_dac_state_t dacState;
   qdsp_note_t                notes[$];
   qdsp_note_t                want;
   logic [3:0][11:0]          inReg;
   logic [31:0]               seed = 32'hBCE9;
   logic [15:0]               word;
   int                        mismatches = 0;
   int                        checked = 0;

   qdsp_command_port DUT (.clock(clock), .sys_rst(sys_rst), .linkIn(linkIn), .echoOut(echoOut),
      .clearAllN(clearAllN), .shutdownLockoutN(lockN), .userLogicOutput(userOut),
      .echoOnRise(echoOnRise), .dacState(dacState));
   qdsp_host_model host (.clock(clock), .linkOut(linkIn), .echoIn(echoOut));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [50:0] exp, input logic [50:0] got, input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   // Works out the effect of a frame, notes it, then sends it
   task automatic frame(input logic [15:0] f, input int n, input bit split, input bit noSel);
      if (n == 16 && !noSel) begin
         if (f[13:12] == qdsp_pkg::CTRL_LOAD || f[13:12] == qdsp_pkg::CTRL_LOADUPD)
            inReg[f[15:14]] = f[11:0];
         if (f[13:12] == qdsp_pkg::CTRL_LOADUPD) want.dac.dacValue = inReg;
         case (f[15:12])
            qdsp_pkg::CMD_UPDATE: begin
               want.dac.dacValue = inReg;
               want.dac.powerDown = 1'b0;
            end
            qdsp_pkg::CMD_LOAD_ALL: begin
               inReg = {4{f[11:0]}};
               want.dac.dacValue = inReg;
               want.dac.powerDown = 1'b0;
            end
            qdsp_pkg::CMD_SHUTDOWN: if (lockN) want.dac.powerDown = 1'b1;
            qdsp_pkg::CMD_USER_LO: want.user = 1'b0;
            qdsp_pkg::CMD_USER_HI: want.user = 1'b1;
            qdsp_pkg::CMD_ECHO0, qdsp_pkg::CMD_ECHO1: begin
               want.rise = f[15:12] == qdsp_pkg::CMD_ECHO1;
               want.dac.dacValue = inReg;
            end
            default: ;
         endcase
      end
      if (!noSel) notes.push_back(want);
      host.send({1'b0, f}, n, split, noSel);
   endtask : frame

   // Lockout pin; a falling edge wakes the device
   task automatic setLock(input logic v);
      repeat (4) @(negedge clock);
      if (!v) begin
         want.dac.powerDown = 1'b0;
         notes.push_back(want);
      end
      lockN = v;
      repeat (8) @(negedge clock);
   endtask : setLock

   // System clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Watchdog
   initial begin
      #2000000;
      mismatches++;
      give_verdict();
   end

   // Compares outputs with the oldest note once each result has landed
   initial begin
      @(negedge sys_rst);
      forever begin
         @(posedge linkIn.csN or negedge clearAllN or negedge lockN);
         repeat (6) @(negedge clock);
         check(notes.pop_front(), {dacState, userOut, echoOnRise}, "outputs");
      end
   end

   // Main sequence
   initial begin
      want = '0;
      inReg = '0;
      repeat (10) @(negedge clock);
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
      check(want, {dacState, userOut, echoOnRise}, "reset state");
      for (int ch = 0; ch < 4; ch++) begin
         seed = lfsr(seed);
         frame({ch[1:0], 2'h1, seed[11:0]}, 16, 0, 0);
      end
      frame({qdsp_pkg::CMD_UPDATE, seed[23:12]}, 16, 0, 0);
      seed = lfsr(seed);
      frame({2'h2, 2'h3, seed[11:0]}, 16, 1, 0);
      frame({qdsp_pkg::CMD_LOAD_ALL, seed[27:16]}, 16, 0, 0);
      frame({qdsp_pkg::CMD_USER_HI, seed[11:0]}, 16, 0, 0);
      frame({qdsp_pkg::CMD_NOP, seed[15:4]}, 16, 0, 0);
      frame({qdsp_pkg::CMD_USER_LO, seed[19:8]}, 16, 0, 0);
      $display("test loads and user output done");
      setLock(1'b0);
      frame({qdsp_pkg::CMD_SHUTDOWN, 12'h000}, 16, 0, 0);
      setLock(1'b1);
      frame({qdsp_pkg::CMD_SHUTDOWN, 12'hFFF}, 16, 0, 0);
      frame({2'h1, 2'h1, seed[15:4]}, 16, 0, 0);
      frame({qdsp_pkg::CMD_UPDATE, 12'h000}, 16, 0, 0);
      frame({qdsp_pkg::CMD_SHUTDOWN, 12'h000}, 16, 0, 0);
      setLock(1'b0);
      setLock(1'b1);
      frame({qdsp_pkg::CMD_SHUTDOWN, 12'h000}, 16, 0, 0);
      frame({qdsp_pkg::CMD_LOAD_ALL, seed[31:20]}, 16, 0, 0);
      $display("test power-down done");
      frame({qdsp_pkg::CMD_LOAD_ALL, 12'hABC}, 15, 0, 0);
      frame({qdsp_pkg::CMD_LOAD_ALL, 12'hABC}, 17, 0, 0);
      frame({qdsp_pkg::CMD_LOAD_ALL, 12'hABC}, 16, 0, 1);
      frame({qdsp_pkg::CMD_NOP, 12'h000}, 16, 0, 0);
      $display("test refused frames done");
      for (int m = 0; m < 2; m++) begin
         seed = lfsr(seed);
         word = {m ? qdsp_pkg::CMD_ECHO0 : qdsp_pkg::CMD_ECHO1, seed[11:0]};
         frame(word, 16, 0, 0);
         frame({qdsp_pkg::CMD_NOP, seed[23:13], 1'b1}, 16, 0, 0);
         check(word, host.echoWord, "echo word");
      end
      $display("test echo modes done");
      frame({qdsp_pkg::CMD_USER_HI, 12'h000}, 16, 0, 0);
      repeat (4) @(negedge clock);
      want = '0;
      inReg = '0;
      notes.push_back(want);
      clearAllN = 1'b0;
      repeat (10) @(negedge clock);
      check(51'h0, echoOut, "echo during clear");
      clearAllN = 1'b1;
      frame({qdsp_pkg::CMD_UPDATE, 12'h000}, 16, 0, 0);
      repeat (8) @(negedge clock);
      $display("test clear done");
      if (notes.size() != 0) begin
         mismatches++;
         $display("wrong value notes left expected 0 seen %0d", notes.size());
      end
      give_verdict();
   end
endmodule : qdsp_command_port_bench

// >>> tb/qdsp_host_model.sv
// Host serial master model that drives the command port link pins
`timescale 1ns/1ps
module qdsp_host_model (
   // Clock
   input  wire logic            clock,
   // Link pins
   output qdsp_pkg::qdsp_link_t linkOut,
   input  wire logic            echoIn
);
   logic        sclkReg  = 1'b0;
   logic        csReg    = 1'b1;
   logic        dinReg   = 1'b0;
   logic        idleFlip = 1'b0;
   logic [15:0] echoWord = 16'h0000;

   // Released data line shows a pattern that changes every cycle
   always @(negedge clock) begin
      idleFlip <= ~idleFlip;
   end

   // Pins as the device sees them
   assign linkOut = '{sclk: sclkReg, csN: csReg, din: csReg ? idleFlip : dinReg};

   // One frame, MSB first, 800 ns serial clock, echo sampled late in each low phase
   task automatic send(input logic [16:0] word, input int n, input bit split, input bit noSel);
      @(negedge clock);
      csReg = noSel;
      for (int k = n - 1; k >= 0; k--) begin
         dinReg = word[k];
         sclkReg = 1'b0;
         if (split && k == 7) repeat (16) @(negedge clock);
         repeat (5) @(negedge clock);
         if (k < n - 1) echoWord = {echoWord[14:0], echoIn};
         sclkReg = 1'b1;
         repeat (3) @(negedge clock);
      end
      sclkReg = 1'b0;
      repeat (5) @(negedge clock);
      echoWord = {echoWord[14:0], echoIn};
      csReg = 1'b1;
      repeat (4) @(negedge clock);
   endtask : send
endmodule : qdsp_host_model
